// ==== design/sfr_defs.svh ====
// Constants of the serial flash instruction block
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH

// ---------------------------------------------------------------
// Instruction codes
// ---------------------------------------------------------------
`define SFR_OP_READ        8'h03
`define SFR_OP_FAST_READ   8'h0B
`define SFR_OP_DUAL_READ   8'h3B
`define SFR_OP_DUAL_IO     8'hBB
`define SFR_OP_OTP_READ    8'h4B
`define SFR_OP_OTP_PROG    8'h42
`define SFR_OP_PAGE_PROG2  8'hA2
`define SFR_OP_WRITE_ENABLE_CMD        8'h06
`define SFR_OP_READ_STATUS 8'h05

// ---------------------------------------------------------------
// Geometry and field positions
// ---------------------------------------------------------------
`define SFR_MEM_AW         22
`define SFR_ADDR_W         24
`define SFR_PAGE_W         8
`define SFR_OTP_W          6
`define SFR_BLOCK_LSB      16
`define SFR_OTP_LOCK_IDX   6'h3F
`define SFR_OTP_LOCK_BIT   0
`define SFR_BYTE_BITS      4'h8
`define SFR_ERASED         8'hFF

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SFR_CLK_PERIOD_NS  10
`define SFR_TPP_US         100
`define SFR_TPP_CNT_W      24

`endif

// ==== design/sfr_pkg.sv ====
// Types shared by the serial flash instruction block
package sfr_pkg;

	// Link-side sequence phase
	typedef enum logic [2:0] {
		SFR_LK_OPC,
		SFR_LK_ADDR,
		SFR_LK_DUMMY,
		SFR_LK_RDATA,
		SFR_LK_WDATA,
		SFR_LK_IGNORE
	} sfr_link_e;

	// Operation handed to the system side at deselect
	typedef enum logic [1:0] {
		SFR_KD_NONE,
		SFR_KD_WRITE_ENABLE_CMD,
		SFR_KD_OTP_PROG,
		SFR_KD_PAGE_PROG
	} sfr_kind_e;

	// Source of read data
	typedef enum logic [1:0] {
		SFR_SRC_MAIN,
		SFR_SRC_OTP,
		SFR_SRC_STATUS
	} sfr_src_e;

	// Self-timed program sequencer
	typedef enum logic [1:0] {
		SFR_SY_IDLE,
		SFR_SY_WRITE,
		SFR_SY_WAIT
	} sfr_sys_e;

endpackage

// ==== design/sfr_core.sv ====
// Serial flash instruction handling: reads, OTP and dual program
//
// Notes on behaviour
// - Main read address wraps to zero at top.
// - Chip select high ends reads, releases pins.
// - Reads and OTP commands refused while busy.
// - Fast read: opcode, address, dummy byte latched rising.
// - Data out on falling edge, address increments.
// - 3Bh reads out two bits per clock.
// - Eight dummy clocks ignored before 3Bh dual data.
// - OTP read ignores high address, auto-increments.
// - OTP program needs latch, ANDs up to 64 bytes.
// - OTP program runs only on byte boundary.
// - OTP program sets busy, clears latch early.
// - OTP lock bit zero freezes whole area.
// - Programmed OTP zero bits never return one.
// - Dual program data arrives two bits per clock.
// - Page data wraps within the same page.
// - Last 256 bytes kept, others untouched.
// - Dual program runs only on byte boundary.
// - Dual program busy, latch cleared before end.
// - Protected pages are never programmed.
// - BBh takes address and gives data on two pins.
// - Page program needs the write enable latch.
`timescale 1ns/1ns
`include "sfr_defs.svh"

module sfr_core
	import sfr_pkg::*;
#(
	parameter int MEM_AW  = `SFR_MEM_AW,
	parameter int TPP_CYC = (`SFR_TPP_US * 1000) / `SFR_CLK_PERIOD_NS
) (
	// System clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       rst_b_in,
	// Serial link
	input  wire logic       sclk_in,
	input  wire logic       cs_b_in,
	input  wire logic       data_pin_primary_in,
	output logic            data_pin_primary_out,
	output logic            data_pin_primary_oe_out,
	input  wire logic       data_pin_secondary_in,
	output logic            data_pin_secondary_out,
	output logic            data_pin_secondary_oe_out,
	// Configuration and status
	input  wire logic [2:0] block_protect_bits_in,
	output logic            write_in_progress_flag_out,
	output logic            write_enable_latch_out
);

	localparam int PAGE_N = 1 << `SFR_PAGE_W;
	localparam int OTP_N  = 1 << `SFR_OTP_W;

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	// Nonvolatile contents are not cleared by reset; they start erased.
	logic [7:0]  mem_arr [0:(1 << MEM_AW) - 1] = '{default: `SFR_ERASED};
	logic [7:0]  otp_arr [0:OTP_N - 1] = '{default: `SFR_ERASED};
	logic [7:0]  pbuf_arr [0:PAGE_N - 1];

	// ---------------------------------------------------------------
	// Link domain: command, address and data capture
	// ---------------------------------------------------------------
	// Sequence counters restart whenever the host deselects.
	wire link_rst_b = rst_b_in & ~cs_b_in;

	sfr_link_e                  state_reg, state_next;
	logic [3:0]                 bitcnt_reg;
	logic [1:0]                 abyte_reg;
	logic [7:0]                 rx_reg;
	logic [7:0]                 op_reg;
	logic [`SFR_ADDR_W-1:0]     addr_reg;
	sfr_kind_e                  kind_reg;
	sfr_src_e                   src_reg;
	logic                       dual_out_reg;
	logic                       armed_reg;
	logic [PAGE_N-1:0]          pmask_reg;
	logic [1:0]                 lsync1_reg, lsync2_reg, lsync3_reg;
	logic [1:0]                 lstat_reg;
	logic [7:0]                 tx_reg;

	wire opc_phase  = (state_reg == SFR_LK_OPC);
	wire op_bb      = (op_reg == `SFR_OP_DUAL_IO);
	// Dual output also steps the bit count by two per clock
	wire rx_dual    = ((state_reg == SFR_LK_ADDR ||
	                    state_reg == SFR_LK_DUMMY) && op_bb) ||
	                  (state_reg == SFR_LK_RDATA && dual_out_reg) ||
	                  (state_reg == SFR_LK_WDATA &&
	                   kind_reg == SFR_KD_PAGE_PROG);
	wire [3:0] bit_next   = bitcnt_reg + (rx_dual ? 4'h2 : 4'h1);
	wire       byte_done  = (bit_next == `SFR_BYTE_BITS);
	wire [7:0] rx_next    = rx_dual ?
	                        {rx_reg[5:0], data_pin_secondary_in,
	                         data_pin_primary_in} :
	                        {rx_reg[6:0], data_pin_primary_in};
	wire       link_busy  = lstat_reg[0];

	// Opcode decode on the eighth bit
	wire is_read   = (rx_next == `SFR_OP_READ);
	wire is_fast   = (rx_next == `SFR_OP_FAST_READ) ||
	                 (rx_next == `SFR_OP_DUAL_READ) ||
	                 (rx_next == `SFR_OP_OTP_READ);
	wire is_bb     = (rx_next == `SFR_OP_DUAL_IO);
	wire is_prog   = (rx_next == `SFR_OP_OTP_PROG) ||
	                 (rx_next == `SFR_OP_PAGE_PROG2);
	wire is_status = (rx_next == `SFR_OP_READ_STATUS);
	wire op_needs_idle = is_read | is_fast | is_bb | is_prog;
	wire do_decode = opc_phase & byte_done;

	// Next read or write address
	wire [MEM_AW-1:0] mem_idx   = addr_reg[MEM_AW-1:0];
	wire [`SFR_OTP_W-1:0] otp_idx = addr_reg[`SFR_OTP_W-1:0];
	wire [MEM_AW-1:0] mem_inc   = mem_idx + 1'b1;
	wire [`SFR_OTP_W-1:0] otp_inc = otp_idx + 1'b1;
	wire [`SFR_PAGE_W-1:0] pg_inc = addr_reg[`SFR_PAGE_W-1:0] + 1'b1;
	wire [`SFR_PAGE_W-1:0] wr_idx = (kind_reg == SFR_KD_OTP_PROG) ?
	                                {2'h0, otp_idx} :
	                                addr_reg[`SFR_PAGE_W-1:0];

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			SFR_LK_OPC: begin
				if (byte_done) begin
					if (op_needs_idle && link_busy) begin
						state_next = SFR_LK_IGNORE;
					end else if (is_read | is_fast | is_bb | is_prog) begin
						state_next = SFR_LK_ADDR;
					end else if (is_status) begin
						state_next = SFR_LK_RDATA;
					end else begin
						state_next = SFR_LK_IGNORE;
					end
				end
			end
			SFR_LK_ADDR: begin
				if (byte_done && abyte_reg == 2'h2) begin
					if (op_reg == `SFR_OP_READ) begin
						state_next = SFR_LK_RDATA;
					end else if (kind_reg == SFR_KD_NONE) begin
						state_next = SFR_LK_DUMMY;
					end else begin
						state_next = SFR_LK_WDATA;
					end
				end
			end
			SFR_LK_DUMMY: begin
				if (byte_done) begin
					state_next = SFR_LK_RDATA;
				end
			end
			SFR_LK_RDATA,
			SFR_LK_WDATA,
			SFR_LK_IGNORE: begin
				state_next = state_reg;
			end
		endcase
	end

	// Sequence position; cleared by deselect
	always_ff @(posedge sclk_in or negedge link_rst_b) begin
		if (!link_rst_b) begin
			state_reg  <= SFR_LK_OPC;
			bitcnt_reg <= 4'h0;
			abyte_reg  <= 2'h0;
			rx_reg     <= 8'h00;
		end else begin
			state_reg  <= state_next;
			bitcnt_reg <= byte_done ? 4'h0 : bit_next;
			rx_reg     <= rx_next;
			if (state_reg == SFR_LK_ADDR && byte_done) begin
				abyte_reg <= abyte_reg + 2'h1;
			end
		end
	end

	// Command context; kept across deselect for the system side
	always_ff @(posedge sclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			op_reg       <= 8'h00;
			addr_reg     <= '0;
			kind_reg     <= SFR_KD_NONE;
			src_reg      <= SFR_SRC_MAIN;
			dual_out_reg <= 1'b0;
			armed_reg    <= 1'b0;
			pmask_reg    <= '0;
		end else begin
			// Only a full byte leaves the command armed at deselect
			armed_reg <= byte_done &&
			             ((opc_phase && rx_next == `SFR_OP_WRITE_ENABLE_CMD) ||
			              state_reg == SFR_LK_WDATA);
			if (do_decode) begin
				op_reg       <= rx_next;
				dual_out_reg <= (rx_next == `SFR_OP_DUAL_READ) | is_bb;
				src_reg      <= is_status ? SFR_SRC_STATUS :
				                (rx_next == `SFR_OP_OTP_READ ||
				                 rx_next == `SFR_OP_OTP_PROG) ?
				                SFR_SRC_OTP : SFR_SRC_MAIN;
				if (rx_next == `SFR_OP_WRITE_ENABLE_CMD) begin
					kind_reg <= SFR_KD_WRITE_ENABLE_CMD;
				end else if (rx_next == `SFR_OP_OTP_PROG && !link_busy) begin
					kind_reg <= SFR_KD_OTP_PROG;
				end else if (rx_next == `SFR_OP_PAGE_PROG2 &&
				             !link_busy) begin
					kind_reg <= SFR_KD_PAGE_PROG;
				end else begin
					kind_reg <= SFR_KD_NONE;
				end
				// Buffer is only rewritten when no program cycle reads it
				if (is_prog && !link_busy) begin
					pmask_reg <= '0;
				end
			end
			if (state_reg == SFR_LK_ADDR) begin
				addr_reg <= rx_dual ?
				            {addr_reg[`SFR_ADDR_W-3:0],
				             data_pin_secondary_in, data_pin_primary_in} :
				            {addr_reg[`SFR_ADDR_W-2:0],
				             data_pin_primary_in};
			end
			if (state_reg == SFR_LK_RDATA && byte_done) begin
				if (src_reg == SFR_SRC_OTP) begin
					addr_reg[`SFR_OTP_W-1:0] <= otp_inc;
				end else if (src_reg == SFR_SRC_MAIN) begin
					addr_reg <= {{(`SFR_ADDR_W-MEM_AW){1'b0}},
					             mem_inc};
				end
			end
			if (state_reg == SFR_LK_WDATA && byte_done) begin
				pmask_reg[wr_idx] <= 1'b1;
				if (kind_reg == SFR_KD_OTP_PROG) begin
					addr_reg[`SFR_OTP_W-1:0] <= otp_inc;
				end else begin
					addr_reg[`SFR_PAGE_W-1:0] <= pg_inc;
				end
			end
		end
	end

	// Later bytes overwrite earlier ones at the same slot
	always_ff @(posedge sclk_in) begin
		if (state_reg == SFR_LK_WDATA && byte_done) begin
			pbuf_arr[wr_idx] <= rx_next;
		end
	end

	// Busy and latch seen from the link clock
	always_ff @(posedge sclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lsync1_reg <= 2'h0;
			lsync2_reg <= 2'h0;
			lsync3_reg <= 2'h0;
			lstat_reg  <= 2'h0;
		end else begin
			lsync1_reg <= {wel_reg, wip_reg};
			lsync2_reg <= lsync1_reg;
			lsync3_reg <= lsync2_reg;
			lstat_reg  <= (lsync2_reg & lsync3_reg) |
			              (lstat_reg & (lsync2_reg | lsync3_reg));
		end
	end

	// ---------------------------------------------------------------
	// Link domain: data output on the falling edge
	// ---------------------------------------------------------------
	wire [7:0] status_byte = {6'h00, lstat_reg[1], lstat_reg[0]};
	wire [7:0] rd_byte = (src_reg == SFR_SRC_STATUS) ? status_byte :
	                     (src_reg == SFR_SRC_OTP) ? otp_arr[otp_idx] :
	                     mem_arr[mem_idx];
	wire       out_start = (bitcnt_reg == 4'h0);
	wire [7:0] out_byte  = out_start ? rd_byte : tx_reg;

	always_ff @(negedge sclk_in or negedge link_rst_b) begin
		if (!link_rst_b) begin
			data_pin_secondary_out    <= 1'b0;
			data_pin_secondary_oe_out <= 1'b0;
			data_pin_primary_out      <= 1'b0;
			data_pin_primary_oe_out   <= 1'b0;
			tx_reg                    <= 8'h00;
		end else if (state_reg == SFR_LK_RDATA) begin
			data_pin_secondary_out    <= out_byte[7];
			data_pin_secondary_oe_out <= 1'b1;
			data_pin_primary_out      <= dual_out_reg & out_byte[6];
			data_pin_primary_oe_out   <= dual_out_reg;
			tx_reg <= dual_out_reg ? {out_byte[5:0], 2'h0} :
			                         {out_byte[6:0], 1'b0};
		end else begin
			data_pin_secondary_oe_out <= 1'b0;
			data_pin_primary_oe_out   <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// System domain: deselect detection and program sequencer
	// ---------------------------------------------------------------
	logic [4:0]                 ssync1_reg, ssync2_reg, ssync3_reg;
	logic [4:0]                 sstat_reg;
	logic                       cs_prev_reg;
	sfr_sys_e                   sys_reg;
	logic [`SFR_PAGE_W-1:0]     idx_reg;
	logic [`SFR_TPP_CNT_W-1:0]  cnt_reg;
	logic                       wip_reg, wel_reg;
	// Job kind held here, as frames during a cycle rewrite kind_reg
	logic                       otp_job_reg;

	wire [4:0] sync_in   = {block_protect_bits_in, armed_reg, cs_b_in};
	wire [4:0] sstat_nx  = (ssync2_reg & ssync3_reg) |
	                       (sstat_reg & (ssync2_reg | ssync3_reg));
	wire       cs_rise   = sstat_reg[0] & ~cs_prev_reg;
	wire       armed_st  = sstat_reg[1];
	wire [2:0] bp_st     = sstat_reg[4:2];

	// Protection covers 64K bytes, doubled per level, down from the top of the array;
	// an array of a single 64K block is covered whole from level 1 up
	wire [MEM_AW-1:0] from_top  = ~mem_idx;
	wire [4:0]        prot_sh   = 5'(`SFR_BLOCK_LSB) + {2'h0, bp_st} - 5'h1;
	wire [MEM_AW+7:0] prot_span = (MEM_AW+8)'(1) << prot_sh;
	wire page_prot = (bp_st != 3'h0) &&
	                 ({8'h00, from_top} < prot_span);
	wire otp_locked = ~otp_arr[`SFR_OTP_LOCK_IDX][`SFR_OTP_LOCK_BIT];
	wire is_otp_job = (kind_reg == SFR_KD_OTP_PROG);
	wire start_otp  = cs_rise && armed_st && is_otp_job && wel_reg &&
	                  !otp_locked;
	wire start_page = cs_rise && armed_st &&
	                  kind_reg == SFR_KD_PAGE_PROG && wel_reg &&
	                  !page_prot;
	wire set_wel    = cs_rise && armed_st && kind_reg == SFR_KD_WRITE_ENABLE_CMD;
	wire last_idx   = otp_job_reg ?
	                  (idx_reg == `SFR_PAGE_W'(OTP_N - 1)) :
	                  (idx_reg == `SFR_PAGE_W'(PAGE_N - 1));
	wire tpp_done   = (cnt_reg == `SFR_TPP_CNT_W'(TPP_CYC - 1));
	wire write_slot = (sys_reg == SFR_SY_WRITE) && pmask_reg[idx_reg];

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ssync1_reg  <= 5'h01;
			ssync2_reg  <= 5'h01;
			ssync3_reg  <= 5'h01;
			sstat_reg   <= 5'h01;
			cs_prev_reg <= 1'b1;
		end else begin
			ssync1_reg  <= sync_in;
			ssync2_reg  <= ssync1_reg;
			ssync3_reg  <= ssync2_reg;
			sstat_reg   <= sstat_nx;
			cs_prev_reg <= sstat_reg[0];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sys_reg <= SFR_SY_IDLE;
			idx_reg <= '0;
			cnt_reg <= '0;
			wip_reg <= 1'b0;
			wel_reg <= 1'b0;
			otp_job_reg <= 1'b0;
		end else begin
			unique case (sys_reg)
				SFR_SY_IDLE: begin
					if (set_wel) begin
						wel_reg <= 1'b1;
					end
					if (start_otp || start_page) begin
						sys_reg <= SFR_SY_WRITE;
						idx_reg <= '0;
						otp_job_reg <= start_otp;
						wip_reg <= 1'b1;
					end
				end
				SFR_SY_WRITE: begin
					idx_reg <= idx_reg + 1'b1;
					if (last_idx) begin
						sys_reg <= SFR_SY_WAIT;
						cnt_reg <= '0;
						wel_reg <= 1'b0;
					end
				end
				SFR_SY_WAIT: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (tpp_done) begin
						sys_reg <= SFR_SY_IDLE;
						wip_reg <= 1'b0;
					end
				end
			endcase
		end
	end

	// Programming only clears bits; untouched slots are skipped
	always_ff @(posedge clk_sys_in) begin
		if (write_slot && otp_job_reg) begin
			otp_arr[idx_reg[`SFR_OTP_W-1:0]] <=
			    otp_arr[idx_reg[`SFR_OTP_W-1:0]] &
			    pbuf_arr[idx_reg];
		end
		if (write_slot && !otp_job_reg) begin
			mem_arr[{addr_reg[MEM_AW-1:`SFR_PAGE_W], idx_reg}] <=
			    mem_arr[{addr_reg[MEM_AW-1:`SFR_PAGE_W], idx_reg}] &
			    pbuf_arr[idx_reg];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			write_in_progress_flag_out <= 1'b0;
			write_enable_latch_out     <= 1'b0;
		end else begin
			write_in_progress_flag_out <= wip_reg;
			write_enable_latch_out     <= wel_reg;
		end
	end

endmodule

// ==== verif/sfr_core_properties.sv ====
// Concurrent checks on the ports of the serial flash instruction block
`timescale 1ns/1ns
module sfr_core_props #(
	parameter int MEM_AW  = 22,
	parameter int TPP_CYC = 10000
) (
	// System side
	input  wire logic       clk_sys_in,
	input  wire logic       rst_b_in,
	// Serial link
	input  wire logic       sclk_in,
	input  wire logic       cs_b_in,
	input  wire logic       data_pin_primary_in,
	input  wire logic       data_pin_primary_out,
	input  wire logic       data_pin_primary_oe_out,
	input  wire logic       data_pin_secondary_in,
	input  wire logic       data_pin_secondary_out,
	input  wire logic       data_pin_secondary_oe_out,
	// Configuration and status
	input  wire logic [2:0] block_protect_bits_in,
	input  wire logic       write_in_progress_flag_out,
	input  wire logic       write_enable_latch_out
);
	logic [15:0] busy_cnt_reg;
	logic [15:0] busy_cnt_next;
	logic        write_in_progress_flag;
	logic        write_enable_latch;

	assign write_in_progress_flag = write_in_progress_flag_out;
	assign write_enable_latch = write_enable_latch_out;
	// Counter instead of a long repetition keeps the tools fast
	assign busy_cnt_next = write_in_progress_flag ? busy_cnt_reg + 16'h0001 : 16'h0000;
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in)
			busy_cnt_reg <= 16'h0000;
		else
			busy_cnt_reg <= busy_cnt_next;
	end

	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);

	oe_release_a: assert property (cs_b_in && $past(cs_b_in) |->
		!data_pin_secondary_oe_out && !data_pin_primary_oe_out)
		else $error("pin driven while deselected");
	dual_pair_a: assert property (data_pin_primary_oe_out |->
		data_pin_secondary_oe_out) else $error("primary driven alone");
	fall_shift_a: assert property (sclk_in && $past(sclk_in) &&
		!cs_b_in && !$past(cs_b_in) |-> $stable({data_pin_primary_out,
		data_pin_secondary_out, data_pin_secondary_oe_out}))
		else $error("output moved while link clock high");
	wip_start_a: assert property ($rose(write_in_progress_flag) |-> cs_b_in && write_enable_latch)
		else $error("busy without deselect or latch");
	wel_clear_a: assert property ($rose(write_in_progress_flag) |-> ##[1:300] !write_enable_latch)
		else $error("latch not cleared during busy");
	wel_drop_a: assert property ($fell(write_enable_latch) |-> write_in_progress_flag)
		else $error("latch cleared outside program");
	tpp_len_a: assert property ($fell(write_in_progress_flag) |-> busy_cnt_reg >= TPP_CYC)
		else $error("program cycle too short");
	busy_bound_a: assert property (write_in_progress_flag |-> busy_cnt_reg < TPP_CYC + 400)
		else $error("busy flag stuck");
	wel_set_a: assert property ($rose(write_enable_latch) |-> cs_b_in)
		else $error("latch set inside a frame");

	cover property ($rose(write_in_progress_flag));
	cover property ($rose(data_pin_primary_oe_out));
	cover property ($fell(write_enable_latch));
endmodule

// ==== verif/sfr_host_model.sv ====
// SPI host model driving the serial link in mode 0
`timescale 1ns/1ns
module sfr_host_model (
	// Device side of both data pins
	input  wire logic pri_dev_in,
	input  wire logic pri_oe_in,
	input  wire logic sec_dev_in,
	input  wire logic sec_oe_in,
	// Link outputs and resolved pin levels
	output logic      sclk_out,
	output logic      cs_b_out,
	output logic      pri_line_out,
	output logic      sec_line_out
);
	logic p_drv, p_val, s_drv, s_val, seen_oe;

	// A released line shows the inverse of the last value, not a held copy
	assign pri_line_out = pri_oe_in ? pri_dev_in : (p_drv ? p_val : ~p_val);
	assign sec_line_out = sec_oe_in ? sec_dev_in : (s_drv ? s_val : ~s_val);

	initial begin
		sclk_out = 1'h0;
		cs_b_out = 1'h1;
		{p_drv, p_val, s_drv, s_val, seen_oe} = 5'h00;
	end
	always @(posedge sec_oe_in or posedge pri_oe_in) seen_oe = 1'h1;

	// Data changes after a falling edge; the clock stands low between frames
	task automatic tick(input logic sv, pv, sd, pd, output logic so, po);
		{s_val, p_val, s_drv, p_drv} = {sv, pv, sd, pd};
		#16 sclk_out = 1'h1;
		so = sec_line_out;
		po = pri_line_out;
		#16 sclk_out = 1'h0;
	endtask
	task automatic start();
		seen_oe = 1'h0;
		#4 cs_b_out = 1'h0;
	endtask
	task automatic send(input logic [7:0] b, input logic dual);
		logic so, po;
		if (dual)
			for (int i = 0; i < 4; i++) tick(b[7-2*i], b[6-2*i], 1, 1, so, po);
		else
			for (int i = 0; i < 8; i++) tick(1'h0, b[7-i], 0, 1, so, po);
	endtask
	// Released pins during dummy clocks, before the first data fall
	task automatic dummy(input int n);
		logic so, po;
		for (int i = 0; i < n; i++) tick(~s_val, ~p_val, 0, 0, so, po);
	endtask
	task automatic recv(input logic dual, output logic [7:0] b);
		logic so, po;
		for (int i = 0; i < (dual ? 4 : 8); i++) begin
			tick(s_val, p_val, 0, 0, so, po);
			b = dual ? {b[5:0], so, po} : {b[6:0], so};
		end
	endtask
	task automatic stop();
		#8 cs_b_out = 1'h1;
		{p_drv, s_drv} = 2'h0;
		#120;
	endtask
endmodule

// ==== verif/tb_serial_flash_read_otp_dual_program.sv ====
// Self-checking bench for the serial flash instruction block
`timescale 1ns/1ns
module tb_serial_flash_read_otp_dual_program;
	localparam int TPP_CYC = 20;
	localparam int MEM_AW  = 16;
	logic       clk, rst_b, sclk, cs_b, p_in, s_in, p_out, p_oe, s_out, s_oe;
	logic       write_in_progress_flag, write_enable_latch;
	logic [2:0] bp;
	int         n_errors, compares;

	sfr_core #(.MEM_AW(MEM_AW), .TPP_CYC(TPP_CYC)) uut (
		.clk_sys_in(clk), .rst_b_in(rst_b), .sclk_in(sclk), .cs_b_in(cs_b),
		.data_pin_primary_in(p_in), .data_pin_primary_out(p_out),
		.data_pin_primary_oe_out(p_oe), .data_pin_secondary_in(s_in),
		.data_pin_secondary_out(s_out), .data_pin_secondary_oe_out(s_oe),
		.block_protect_bits_in(bp), .write_in_progress_flag_out(write_in_progress_flag),
		.write_enable_latch_out(write_enable_latch));
	sfr_host_model host (
		.pri_dev_in(p_out), .pri_oe_in(p_oe), .sec_dev_in(s_out),
		.sec_oe_in(s_oe), .sclk_out(sclk), .cs_b_out(cs_b),
		.pri_line_out(p_in), .sec_line_out(s_in));

	always #5 clk = ~clk;

	task automatic report_and_stop();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic write_enable_cmd();
		host.start();
		host.send(8'h06, 1'h0);
		host.stop();
	endtask
	task automatic pg(input logic [7:0] op, input logic [23:0] a,
		input logic [31:0] d, input int n, input int extra);
		host.start();
		host.send(op, 1'h0);
		for (int k = 0; k < 3; k++) host.send(a[23-8*k -: 8], 1'h0);
		for (int i = 0; i < n; i++) host.send(d[31-8*i -: 8], op == 8'hA2);
		if (extra > 0) host.dummy(extra);
		host.stop();
	endtask
	task automatic rd(input logic [7:0] op, input logic [23:0] a,
		input int n, input logic [31:0] e);
		logic [7:0] b;
		host.start();
		host.send(op, 1'h0);
		for (int k = 0; k < 3; k++) host.send(a[23-8*k -: 8], op == 8'hBB);
		if (op == 8'hBB) host.dummy(4);
		else if (op != 8'h03) host.dummy(8);
		for (int i = 0; i < n; i++) begin
			host.recv(op == 8'h3B || op == 8'hBB, b);
			chk("read data", e[31-8*i -: 8], b);
		end
		// Cut the frame in mid-byte
		host.dummy(3);
		host.stop();
		chk("pins released", 8'h00, {6'h00, s_oe, p_oe});
	endtask
	task automatic prog_done(input logic busy);
		logic seen;
		int   i;
		seen = 1'h0;
		for (i = 0; i < 40; i++) begin
			@(negedge clk);
			if (write_in_progress_flag === 1'h1) seen = 1'h1;
		end
		chk("program started", {7'h00, busy}, {7'h00, seen});
		for (i = 0; i < 3000 && write_in_progress_flag !== 1'h0; i++) @(negedge clk);
		if (i == 3000) begin
			n_errors++;
			$display("[FAIL] busy flag expected 0 seen 1");
			report_and_stop();
		end
	endtask

	task automatic t_no_latch();
		pg(8'hA2, 24'h000020, 32'h00000000, 1, 0);
		prog_done(1'h0);
	endtask
	task automatic t_page();
		write_enable_cmd();
		chk("latch", 8'h01, {7'h00, write_enable_latch});
		pg(8'hA2, 24'h0000FE, 32'h11223344, 4, 0);
		prog_done(1'h1);
		chk("latch", 8'h00, {7'h00, write_enable_latch});
	endtask
	task automatic t_reads();
		rd(8'h03, 24'h00FFFF, 4, 32'hFF3344FF);
		rd(8'h0B, 24'h00FFFF, 4, 32'hFF3344FF);
		rd(8'h3B, 24'h00FFFF, 4, 32'hFF3344FF);
		rd(8'hBB, 24'h00FFFF, 4, 32'hFF3344FF);
	endtask
	task automatic t_busy();
		logic [7:0] b;
		write_enable_cmd();
		pg(8'hA2, 24'h000200, 32'h55000000, 1, 0);
		rd(8'h0B, 24'h000000, 0, 32'h00000000);
		chk("refused drive", 8'h00, {7'h00, host.seen_oe});
		// Status stays readable while the program cycle runs
		host.start();
		host.send(8'h05, 1'h0);
		host.recv(1'h0, b);
		host.stop();
		chk("status busy", 8'h01, {7'h00, b[0]});
		prog_done(1'h1);
		rd(8'h03, 24'h000200, 2, 32'h55FF0000);
	endtask
	task automatic t_otp();
		write_enable_cmd();
		pg(8'h42, 24'hFFFFC5, 32'hF0000000, 1, 0);
		prog_done(1'h1);
		write_enable_cmd();
		pg(8'h42, 24'h000005, 32'h0F000000, 1, 0);
		prog_done(1'h1);
		rd(8'h4B, 24'h000045, 2, 32'h00FF0000);
	endtask
	task automatic t_partial();
		write_enable_cmd();
		pg(8'h42, 24'h000007, 32'h00000000, 1, 3);
		prog_done(1'h0);
		pg(8'hA2, 24'h000030, 32'h00000000, 1, 2);
		prog_done(1'h0);
		chk("latch kept", 8'h01, {7'h00, write_enable_latch});
	endtask
	task automatic t_lock();
		pg(8'h42, 24'h00003F, 32'hFE000000, 1, 0);
		prog_done(1'h1);
		write_enable_cmd();
		pg(8'h42, 24'h000006, 32'h00000000, 1, 0);
		prog_done(1'h0);
		rd(8'h4B, 24'h00003F, 2, 32'hFEFF0000);
	endtask
	task automatic t_protect();
		@(negedge clk);
		bp = 3'h1;
		pg(8'hA2, 24'h000010, 32'h00000000, 1, 0);
		prog_done(1'h0);
		@(negedge clk);
		bp = 3'h0;
		rd(8'h03, 24'h000010, 1, 32'hFF000000);
	endtask

	initial begin
		clk = 1'h0;
		rst_b = 1'h0;
		bp = 3'h0;
		n_errors = 0;
		compares = 0;
		repeat (8) @(negedge clk);
		rst_b = 1'h1;
		repeat (4) @(negedge clk);
		t_no_latch();
		t_page();
		t_reads();
		t_busy();
		t_otp();
		t_partial();
		t_lock();
		t_protect();
		report_and_stop();
	end
endmodule

bind sfr_core sfr_core_props #(.MEM_AW(MEM_AW), .TPP_CYC(TPP_CYC)) props (
	.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .sclk_in(sclk_in),
	.cs_b_in(cs_b_in), .data_pin_primary_in(data_pin_primary_in),
	.data_pin_primary_out(data_pin_primary_out),
	.data_pin_primary_oe_out(data_pin_primary_oe_out),
	.data_pin_secondary_in(data_pin_secondary_in),
	.data_pin_secondary_out(data_pin_secondary_out),
	.data_pin_secondary_oe_out(data_pin_secondary_oe_out),
	.block_protect_bits_in(block_protect_bits_in),
	.write_in_progress_flag_out(write_in_progress_flag_out),
	.write_enable_latch_out(write_enable_latch_out));
